// [common/rcs_pkg.sv]
// constants and types for the reference clock switchover controller
package rcs_pkg;

  // ***************************************************
  // timing
  // ***************************************************
  localparam int CLK_PERIOD_PS = 5000;
  localparam int REF_PERIOD_NS = 40;
  localparam int LOSS_PERIODS = 2;
  localparam int LOSS_CYCLES = (REF_PERIOD_NS * 1000 * LOSS_PERIODS) / CLK_PERIOD_PS;
  localparam int SYNTH_RST_NS = 10;
  localparam int SYNTH_RST_CYCLES = (SYNTH_RST_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ***************************************************
  // sizes
  // ***************************************************
  localparam int NUM_REFS = 2;
  localparam int NUM_DIVS = 6;
  localparam int NUM_TAPS = 8;
  localparam int TAP_W = 3;
  localparam int CNT_W = 9;
  localparam int LOSS_W = 16;

  // ***************************************************
  // register map (byte addresses)
  // ***************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_LOSS_LIMIT = 8'h08;
  localparam logic [7:0] ADDR_PHASE_BASE = 8'h0C;
  localparam logic [7:0] ADDR_PHASE_LAST = 8'h20;

  // ctrl fields
  localparam int CTRL_AUTO_BIT = 0;
  localparam int CTRL_PFD_BIT = 1;
  localparam int CTRL_SRST_BIT = 2;
  localparam logic [2:0] CTRL_RST = 3'h3;

  // phase register fields
  localparam int PH_TAP_LSB = 0;
  localparam int PH_CNT_LSB = 8;
  localparam int PH_RUN_BIT = 24;
  localparam logic [TAP_W-1:0] TAP_RST = 3'h0;
  localparam logic [CNT_W-1:0] CNT_RST = 9'h001;

  localparam logic [LOSS_W-1:0] LOSS_LIMIT_RST = LOSS_W'(LOSS_CYCLES);

  // ***************************************************
  // types
  // ***************************************************
  typedef enum logic {
    REF_PRIMARY,
    REF_SECONDARY
  } rcs_ref_t;

  typedef struct packed {
    logic lock;
    logic busy;
    logic active;
    logic lost1;
    logic lost0;
  } rcs_status_t;

  typedef struct packed {
    logic [CNT_W-1:0] init_cnt;
    logic [TAP_W-1:0] tap;
  } rcs_phase_t;

endpackage

// [verilog/rcs_switchover.sv]
// reference clock switchover controller with phase shift selection
//
// Operation
// R01: input held low two periods flags lost
// R02: failed current reference selects secondary input
// R03: automatic switch lands on available falling edge
// R04: rising edge of manual request starts switch
// R05: requester holds request three longer-period cycles
// R06: outgoing falling edge gates counter reference off
// R07: incoming falling edge selects, updates active indication
// R08: manual override: active follows request, no lost
// R09: falling request keeps selection; each rise repeats
// R10: switch waits until target input is available
// R11: held request blocks automatic switching entirely
// R12: request raised only while both references run
// R13: manual mode uses same edge-sensitive switching
// R14: automatic mode needs references within twenty percent
// R15: controller pulses synth reset, awaits lock; here synth_reset follows ctrl bit 2, lock is only read in status
// R16: lost flags may clear phase detector enable
// R17: each divider picks one of eight taps
// R18: fine step is one eighth oscillator period
// R19: coarse shift delays start by count minus one
// R20: outputs two lost flags and active indication
// R21: automatic switching repeats back and forth freely
// R22: lost flag clears once input toggles again
// R23: synth reset returns primary, clears lost flags
`timescale 1ns/1ps
`default_nettype none

module rcs_switchover
  import rcs_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // reference inputs and manual request
  input wire logic ref_clk_primary,
  input wire logic ref_clk_secondary,
  input wire logic switch_req,
  // synthesizer status and oscillator period tick
  input wire logic synth_locked,
  input wire logic vco_tick,
  // switchover status
  output logic primary_lost_flag,
  output logic secondary_lost_flag,
  output logic active_input,
  // reference multiplexer
  output logic ref_sel,
  output logic ref_gate_en,
  output logic ref_out,
  // synthesizer control
  output logic phase_freq_detector_en,
  output logic synth_reset,
  // divider phase control
  output logic [NUM_DIVS-1:0][TAP_W-1:0] div_tap,
  output logic [NUM_DIVS-1:0] div_run
);

  // ***************************************************
  // declarations
  // ***************************************************
  typedef enum logic [1:0] {
    SW_IDLE,
    SW_GATE,
    SW_ENGAGE
  } rcs_sw_state_t;

  rcs_sw_state_t sw_state;
  logic [NUM_REFS-1:0] ref_s1;
  logic [NUM_REFS-1:0] ref_s2;
  logic [NUM_REFS-1:0] ref_s3;
  logic [NUM_REFS-1:0] ref_lvl;
  logic [NUM_REFS-1:0] ref_fall;
  logic [NUM_REFS-1:0] ref_rise;
  logic [NUM_REFS-1:0] lost;
  logic [NUM_REFS-1:0][LOSS_W-1:0] low_cnt;
  logic req_s1;
  logic req_s2;
  logic req_s3;
  logic req_lvl;
  logic req_rise;
  logic lock_s1;
  logic lock_s2;
  logic lock_s3;
  logic lock_lvl;
  logic [2:0] ctrl;
  logic [LOSS_W-1:0] loss_limit;
  rcs_phase_t [NUM_DIVS-1:0] phase_cfg;
  logic [NUM_DIVS-1:0][CNT_W-1:0] start_cnt;
  logic fsm_clear;
  logic cur;
  logic tgt;
  logic auto_trig;
  logic [31:0] rd_val;
  logic acc_write;
  rcs_status_t status;

  // ***************************************************
  // input synchronisers
  // ***************************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      ref_s1 <= '0;
      ref_s2 <= '0;
      ref_s3 <= '0;
      ref_lvl <= '0;
    end else begin
      ref_s1 <= {ref_clk_secondary, ref_clk_primary};
      ref_s2 <= ref_s1;
      ref_s3 <= ref_s2;
      for (int i = 0; i < NUM_REFS; i++) begin
        if (ref_s2[i] == ref_s3[i]) begin
          ref_lvl[i] <= ref_s3[i];
        end
      end
    end
  end

  assign ref_fall = ref_lvl & ~(ref_s2 ^ ref_s3) & ~ref_s3;
  assign ref_rise = ~ref_lvl & ~(ref_s2 ^ ref_s3) & ref_s3;

  always_ff @(posedge mclk) begin
    if (rst) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      req_s3 <= 1'b0;
      req_lvl <= 1'b0;
      lock_s1 <= 1'b0;
      lock_s2 <= 1'b0;
      lock_s3 <= 1'b0;
      lock_lvl <= 1'b0;
    end else begin
      req_s1 <= switch_req;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
      lock_s1 <= synth_locked;
      lock_s2 <= lock_s1;
      lock_s3 <= lock_s2;
      if (req_s2 == req_s3) begin
        req_lvl <= req_s3;
      end
      if (lock_s2 == lock_s3) begin
        lock_lvl <= lock_s3;
      end
    end
  end

  // positive edge only; a fall does nothing (see R04) (see R09)
  assign req_rise = !req_lvl && (req_s2 == req_s3) && req_s3;

  // ***************************************************
  // clock sense
  // ***************************************************
  assign fsm_clear = ctrl[CTRL_SRST_BIT];

  always_ff @(posedge mclk) begin
    if (rst || fsm_clear) begin
      low_cnt <= '0;
      lost <= '0; // see R23
    end else begin
      for (int i = 0; i < NUM_REFS; i++) begin
        if (ref_lvl[i] || ref_rise[i]) begin
          low_cnt[i] <= '0;
        end else if (low_cnt[i] != loss_limit) begin
          low_cnt[i] <= low_cnt[i] + LOSS_W'(1);
        end
        if (ref_rise[i]) begin
          lost[i] <= 1'b0; // see R22
        end else if (!ref_lvl[i] && low_cnt[i] == loss_limit) begin
          lost[i] <= 1'b1; // see R01
        end
      end
    end
  end

  // ***************************************************
  // switchover state machine
  // ***************************************************
  assign tgt = ~cur;
  // held request blocks automatic action (see R11) (see R02) (see R21)
  assign auto_trig = ctrl[CTRL_AUTO_BIT] && !req_lvl && lost[cur];

  always_ff @(posedge mclk) begin
    if (rst || fsm_clear) begin
      sw_state <= SW_IDLE;
      cur <= REF_PRIMARY; // see R23
      ref_gate_en <= 1'b1;
    end else begin
      case (sw_state)
        SW_IDLE: begin
          // manual and pure manual share this path (see R04) (see R13)
          if (req_rise || auto_trig) begin
            sw_state <= SW_GATE;
          end
        end
        SW_GATE: begin
          // gate on outgoing fall, or at once if it is dead (see R06) (see R03)
          if (ref_fall[cur] || lost[cur]) begin
            ref_gate_en <= 1'b0;
            sw_state <= SW_ENGAGE;
          end
        end
        SW_ENGAGE: begin
          // wait for an available target, land on its fall (see R10) (see R07) (see R03)
          if (ref_fall[tgt] && !lost[tgt]) begin
            cur <= tgt;
            ref_gate_en <= 1'b1;
            sw_state <= SW_IDLE;
          end
        end
        default: begin
          sw_state <= SW_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      primary_lost_flag <= 1'b0;
      secondary_lost_flag <= 1'b0;
      ref_sel <= 1'b0;
      active_input <= 1'b0;
      ref_out <= 1'b0;
    end else begin
      primary_lost_flag <= lost[0]; // see R20
      secondary_lost_flag <= lost[1]; // see R20
      ref_sel <= cur; // see R02
      active_input <= cur; // see R07 (see R08)
      ref_out <= ref_gate_en && ref_lvl[cur]; // see R06
    end
  end

  // ***************************************************
  // divider phase control
  // ***************************************************
  generate
    for (genvar d = 0; d < NUM_DIVS; d++) begin : g_div
      always_ff @(posedge mclk) begin
        if (rst || synth_reset) begin
          start_cnt[d] <= '0;
          div_run[d] <= 1'b0;
        end else if (!div_run[d]) begin
          // start after init minus one oscillator periods (see R19)
          if (phase_cfg[d].init_cnt <= CNT_W'(1) ||
              start_cnt[d] == phase_cfg[d].init_cnt - CNT_W'(1)) begin
            div_run[d] <= 1'b1;
          end else if (vco_tick) begin
            start_cnt[d] <= start_cnt[d] + CNT_W'(1);
          end
        end
      end

      always_ff @(posedge mclk) begin
        if (rst) begin
          div_tap[d] <= TAP_RST;
        end else begin
          div_tap[d] <= phase_cfg[d].tap; // see R17 (see R18)
        end
      end
    end
  endgenerate

  // ***************************************************
  // synthesizer control
  // ***************************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      phase_freq_detector_en <= 1'b1;
      synth_reset <= 1'b0;
    end else begin
      phase_freq_detector_en <= ctrl[CTRL_PFD_BIT]; // see R16
      synth_reset <= ctrl[CTRL_SRST_BIT]; // see R15
    end
  end

  // ***************************************************
  // register bus
  // ***************************************************
  assign status = '{lock: lock_lvl, busy: (sw_state != SW_IDLE), active: cur,
                    lost1: lost[1], lost0: lost[0]};
  assign acc_write = avs_write && !avs_waitrequest;

  always_comb begin
    rd_val = '0;
    if (avs_address == ADDR_CTRL) begin
      rd_val[2:0] = ctrl;
    end else if (avs_address == ADDR_STATUS) begin
      rd_val[4:0] = status;
    end else if (avs_address == ADDR_LOSS_LIMIT) begin
      rd_val[LOSS_W-1:0] = loss_limit;
    end else if (avs_address >= ADDR_PHASE_BASE && avs_address <= ADDR_PHASE_LAST &&
                 avs_address[1:0] == 2'h0) begin
      for (int d = 0; d < NUM_DIVS; d++) begin
        if (avs_address == ADDR_PHASE_BASE + 8'(d * 4)) begin
          rd_val[PH_TAP_LSB +: TAP_W] = phase_cfg[d].tap;
          rd_val[PH_CNT_LSB +: CNT_W] = phase_cfg[d].init_cnt;
          rd_val[PH_RUN_BIT] = div_run[d];
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= '0;
    end else if (avs_waitrequest && (avs_read || avs_write)) begin
      avs_waitrequest <= 1'b0;
      avs_readdata <= rd_val;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl <= CTRL_RST;
      loss_limit <= LOSS_LIMIT_RST;
    end else if (acc_write) begin
      if (avs_address == ADDR_CTRL && avs_byteenable[0]) begin
        ctrl <= avs_writedata[2:0];
      end else if (avs_address == ADDR_LOSS_LIMIT) begin
        if (avs_byteenable[0]) begin
          loss_limit[7:0] <= avs_writedata[7:0];
        end
        if (avs_byteenable[1]) begin
          loss_limit[15:8] <= avs_writedata[15:8];
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int d = 0; d < NUM_DIVS; d++) begin
        phase_cfg[d] <= '{init_cnt: CNT_RST, tap: TAP_RST};
      end
    end else if (acc_write) begin
      for (int d = 0; d < NUM_DIVS; d++) begin
        if (avs_address == ADDR_PHASE_BASE + 8'(d * 4)) begin
          if (avs_byteenable[0]) begin
            phase_cfg[d].tap <= avs_writedata[PH_TAP_LSB +: TAP_W];
          end
          if (avs_byteenable[1] && avs_byteenable[2]) begin
            phase_cfg[d].init_cnt <= avs_writedata[PH_CNT_LSB +: CNT_W];
          end
        end
      end
    end
  end

endmodule

`default_nettype wire

// [test/rcs_ref_model.sv]
// two reference clock sources with stop controls
`timescale 1ns/1ps
`default_nettype none
module rcs_ref_model
  import rcs_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // source run enables
  input wire logic [1:0] run,
  // references, a stopped one stays low
  output logic ref_clk_primary,
  output logic ref_clk_secondary
);
  logic [1:0] ph;
  // both 40 ns, same rate, offset phase
  always_ff @(posedge mclk) begin
    if (rst) begin
      ph <= 2'h0;
      ref_clk_primary <= 1'b0;
      ref_clk_secondary <= 1'b0;
    end else begin
      ph <= ph + 2'h1;
      if (ph == 2'h3) begin
        ref_clk_primary <= run[0] & ~ref_clk_primary;
      end
      if (ph == 2'h1) begin
        ref_clk_secondary <= run[1] & ~ref_clk_secondary;
      end
    end
  end
endmodule
`default_nettype wire

// [test/rcs_switchover_props.sv]
// assertions on the switchover controller ports
`timescale 1ns/1ps
`default_nettype none
module rcs_switchover_props
  import rcs_pkg::*;
(
  // watched ports
  input wire logic mclk,
  input wire logic rst,
  input wire logic avs_write,
  input wire logic ref_clk_primary,
  input wire logic switch_req,
  input wire logic synth_reset,
  input wire logic primary_lost_flag,
  input wire logic secondary_lost_flag,
  input wire logic active_input,
  input wire logic ref_sel,
  input wire logic ref_gate_en,
  input wire logic ref_out,
  input wire logic phase_freq_detector_en
);
  logic [7:0] low_cnt;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // cycles the primary input has been low
  always_ff @(posedge mclk) begin
    if (rst || synth_reset || ref_clk_primary) begin
      low_cnt <= 8'h00;
    end else if (low_cnt != 8'hFF) begin
      low_cnt <= low_cnt + 8'h01;
    end
  end
  AST_RST_STATE: assert property (disable iff (1'b0) rst |=> !active_input && ref_gate_en
    && !primary_lost_flag && !secondary_lost_flag && phase_freq_detector_en) else $error("bad reset state");
  AST_SEL_MATCH: assert property (ref_sel == active_input) else $error("select and indication differ");
  AST_SEL_GATED: assert property ($changed(ref_sel) |-> !$past(ref_gate_en) || !$past(ref_gate_en, 2)
    || synth_reset || $past(synth_reset)) else $error("select moved while reference ungated");
  AST_OUT_GATED: assert property (!ref_gate_en && !$past(ref_gate_en) |-> !ref_out)
    else $error("reference passed while gated");
  AST_LOST_SET: assert property (low_cnt == 8'h18 |-> primary_lost_flag) else $error("lost flag late");
  AST_LOST_MIN: assert property ($rose(primary_lost_flag) |-> low_cnt >= 8'h10)
    else $error("lost flag early");
  AST_LOST_CLR: assert property (primary_lost_flag && $rose(ref_clk_primary) |-> ##[1:8] !primary_lost_flag)
    else $error("lost flag stuck");
  AST_TARGET_OK: assert property ($rose(active_input) |-> !secondary_lost_flag)
    else $error("switched to lost input");
  AST_AUTO: assert property (primary_lost_flag && !active_input && !secondary_lost_flag && !switch_req
    && !synth_reset |-> ##[1:60] (active_input || switch_req || synth_reset)) else $error("no automatic switch");
  AST_PFD: assert property ($changed(phase_freq_detector_en) |-> $past(avs_write, 2))
    else $error("detector enable moved alone");
endmodule
bind rcs_switchover rcs_switchover_props chk_u (.mclk(mclk), .rst(rst), .avs_write(avs_write),
  .ref_clk_primary(ref_clk_primary), .switch_req(switch_req), .synth_reset(synth_reset),
  .primary_lost_flag(primary_lost_flag), .secondary_lost_flag(secondary_lost_flag),
  .active_input(active_input), .ref_sel(ref_sel), .ref_gate_en(ref_gate_en), .ref_out(ref_out),
  .phase_freq_detector_en(phase_freq_detector_en));
`default_nettype wire

// [test/rcs_switchover_tb_top.sv]
// self-checking bench for the switchover controller
`timescale 1ns/1ps
`default_nettype none
module rcs_switchover_tb_top
  import rcs_pkg::*;
;
  logic mclk = 1'b0;
  logic rst, avs_read, avs_write, switch_req, synth_locked, vco_tick, avs_waitrequest;
  logic primary_lost_flag, secondary_lost_flag, active_input, ref_sel, ref_gate_en, ref_out;
  logic phase_freq_detector_en, synth_reset, ref_clk_primary, ref_clk_secondary;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [1:0] run, vco_cnt;
  logic [NUM_DIVS-1:0][TAP_W-1:0] div_tap;
  logic [NUM_DIVS-1:0] div_run;
  int errors, comparisons;
  wire logic [2:0] mon = {secondary_lost_flag, primary_lost_flag, active_input};
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) begin
    if (rst) begin
      vco_cnt <= 2'h0;
      vco_tick <= 1'b0;
    end else begin
      vco_cnt <= vco_cnt + 2'h1;
      vco_tick <= (vco_cnt == 2'h3);
    end
  end
  rcs_ref_model src_u (.mclk(mclk), .rst(rst), .run(run), .ref_clk_primary(ref_clk_primary),
    .ref_clk_secondary(ref_clk_secondary));
  rcs_switchover dut_u (.mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ref_clk_primary(ref_clk_primary),
    .ref_clk_secondary(ref_clk_secondary), .switch_req(switch_req), .synth_locked(synth_locked),
    .vco_tick(vco_tick), .primary_lost_flag(primary_lost_flag), .secondary_lost_flag(secondary_lost_flag),
    .active_input(active_input), .ref_sel(ref_sel), .ref_gate_en(ref_gate_en), .ref_out(ref_out),
    .phase_freq_detector_en(phase_freq_detector_en), .synth_reset(synth_reset), .div_tap(div_tap),
    .div_run(div_run));
  task automatic end_sim();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic give_up();
    errors++;
    end_sim();
  endtask
  task automatic cmp1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one bus access, read data checked against d
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) give_up();
    if (!wr) cmp32(avs_readdata, d);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(negedge mclk);
  endtask
  task automatic set_in(input logic s, input logic [1:0] r);
    @(posedge mclk);
    switch_req <= s;
    run <= r;
  endtask
  task automatic wait_sig(input int sel, input logic v);
    int n;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (mon[sel] !== v && n < 200);
    if (mon[sel] !== v) give_up();
    cmp1(mon[sel], v);
  endtask
  task automatic chk_regs();
    bus(1'b0, ADDR_CTRL, 32'(CTRL_RST));
    bus(1'b0, ADDR_LOSS_LIMIT, 32'(LOSS_LIMIT_RST));
    bus(1'b0, ADDR_PHASE_BASE, 32'h01000100);
    bus(1'b1, ADDR_STATUS, 32'h0000001F);
    bus(1'b0, 8'hFC, 32'h00000000);
    bus(1'b0, ADDR_STATUS, 32'h00000010);
  endtask
  task automatic chk_manual();
    set_in(1'b1, 2'b11);
    wait_sig(0, 1'b1);
    cmp1(primary_lost_flag | secondary_lost_flag, 1'b0);
    repeat (24) @(negedge mclk);
    set_in(1'b0, 2'b11);
    repeat (40) @(negedge mclk);
    cmp1(active_input, 1'b1);
    bus(1'b1, ADDR_CTRL, 32'h00000002);
    set_in(1'b1, 2'b11);
    wait_sig(0, 1'b0);
    repeat (24) @(negedge mclk);
    set_in(1'b0, 2'b11);
    bus(1'b1, ADDR_CTRL, 32'h00000003);
  endtask
  task automatic chk_auto();
    set_in(1'b0, 2'b10);
    wait_sig(1, 1'b1);
    wait_sig(0, 1'b1);
    set_in(1'b0, 2'b11);
    wait_sig(1, 1'b0);
    set_in(1'b0, 2'b01);
    wait_sig(2, 1'b1);
    wait_sig(0, 1'b0);
    set_in(1'b0, 2'b11);
    wait_sig(2, 1'b0);
    set_in(1'b1, 2'b11);
    wait_sig(0, 1'b1);
    set_in(1'b1, 2'b01);
    wait_sig(2, 1'b1);
    repeat (40) @(negedge mclk);
    cmp1(active_input, 1'b1);
    set_in(1'b0, 2'b01);
    wait_sig(0, 1'b0);
    set_in(1'b0, 2'b11);
    wait_sig(2, 1'b0);
  endtask
  task automatic chk_srst();
    int k;
    k = 0;
    bus(1'b1, ADDR_PHASE_BASE + 8'h04, 32'h00000305);
    set_in(1'b1, 2'b11);
    wait_sig(0, 1'b1);
    repeat (24) @(negedge mclk);
    set_in(1'b0, 2'b11);
    bus(1'b1, ADDR_CTRL, 32'h00000005);
    // control copies settle one edge later, divider reset one more
    repeat (2) @(negedge mclk);
    cmp1(synth_reset, 1'b1);
    cmp1(phase_freq_detector_en, 1'b0);
    cmp1(div_tap[1] === 3'h5, 1'b1);
    cmp1(div_run[1], 1'b0);
    wait_sig(0, 1'b0);
    bus(1'b1, ADDR_CTRL, 32'h00000003);
    // skip the cycle in which synth reset still holds the divider
    @(negedge mclk);
    for (int i = 0; i < 100 && div_run[1] !== 1'b1; i++) begin
      if (vco_tick === 1'b1) k++;
      @(negedge mclk);
    end
    if (div_run[1] !== 1'b1) give_up();
    cmp32(32'(k), 32'h00000002);
    bus(1'b0, ADDR_PHASE_BASE + 8'h04, 32'h01000305);
  endtask
  initial begin
    rst = 1'b1;
    avs_address = 8'h00;
    avs_writedata = 32'h00000000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    switch_req = 1'b0;
    synth_locked = 1'b1;
    run = 2'b11;
    errors = 0;
    comparisons = 0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    repeat (40) @(negedge mclk);
    chk_regs();
    chk_manual();
    chk_auto();
    chk_srst();
    end_sim();
  end
endmodule
`default_nettype wire
